// file: shared/alu_branch_pkg.sv
package alu_branch_pkg;
    // single-byte-opcode encodings
    localparam logic [7:0] OP_ADD_IMM = 8'h03;
    localparam logic [7:0] OP_ADD_WITH_CARRY_IMM = 8'h13;
    localparam logic [7:0] OP_ORL_IMM = 8'h43;
    localparam logic [7:0] OP_ANL_IMM = 8'h53;
    localparam logic [7:0] OP_XRL_IMM = 8'hD3;
    localparam logic [7:0] OP_DEC_A = 8'h07;
    localparam logic [7:0] OP_INC_A = 8'h17;
    localparam logic [7:0] OP_CLR_A = 8'h27;
    localparam logic [7:0] OP_CPL_A = 8'h37;
    localparam logic [7:0] OP_SWAP_A = 8'h47;
    localparam logic [7:0] OP_DECIMAL_ADJUST = 8'h57;
    localparam logic [7:0] OP_ROT_RIGHT_CARRY = 8'h67;
    localparam logic [7:0] OP_ROT_RIGHT = 8'h77;
    localparam logic [7:0] OP_ROT_LEFT = 8'hE7;
    localparam logic [7:0] OP_ROT_LEFT_CARRY = 8'hF7;
    localparam logic [7:0] OP_INDIRECT_PAGE_JUMP = 8'hB3;
    localparam logic [7:0] OP_BRANCH_INPUT_EMPTY = 8'hD6;
    localparam logic [7:0] OP_BRANCH_OUTPUT_FULL = 8'h86;
    localparam logic [7:0] OP_BRANCH_TIMER = 8'h16;
    localparam logic [7:0] OP_BRANCH_CARRY = 8'hF6;
    localparam logic [7:0] OP_CLR_FLAG_ONE = 8'hA5;
    localparam logic [7:0] OP_CPL_FLAG_ONE = 8'hB5;
    localparam logic [7:0] OP_HOST_READ = 8'h22;
    localparam logic [7:0] OP_HOST_WRITE = 8'h02;
    // opcode groups: high nibble, low nibble 8+r (register) or 0+r (indirect)
    localparam logic [3:0] GRP_INC = 4'h1;
    localparam logic [3:0] GRP_ORL = 4'h4;
    localparam logic [3:0] GRP_ANL = 4'h5;
    localparam logic [3:0] GRP_ADD = 4'h6;
    localparam logic [3:0] GRP_ADD_WITH_CARRY = 4'h7;
    localparam logic [3:0] GRP_DEC = 4'hC;
    localparam logic [3:0] GRP_XRL = 4'hD;
    localparam logic [3:0] GRP_DEC_BRANCH = 4'hE;
    // low five bits of the jump and bit-test forms
    localparam logic [4:0] LOW_JUMP = 5'h04;
    localparam logic [4:0] LOW_BIT_TEST = 5'h12;
    // decimal adjust
    localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
    localparam logic [7:0] BCD_LOW_FIX = 8'h06;
    localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
    // values after reset
    localparam logic [10:0] PC_RST = 11'h000;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [7:0] OPCODE_RST = 8'h00;
endpackage : alu_branch_pkg

// file: hw/alu_branch_core.sv
`timescale 1ns/100ps
// Summary of operation
// - add immediate, register or indirect byte; flags
// - add with carry includes carry in sum
// - carry is overflow, auxiliary is bit-3 carry
// - and/or into accumulator, carries unchanged
// - exclusive-or into accumulator, carries unchanged
// - accumulator increment/decrement, carries unchanged
// - 0x27 clears, 0x37 complements accumulator
// - 0x57 decimal adjust, updates both carries
// - 0x47 swaps accumulator nibbles
// - rotate left plain and through carry
// - rotate right plain and through carry
// - register inc/dec and indirect increment
// - jump: opcode bits 7:5 plus second byte
// - indirect page jump, next page at 255
// - branch when selected accumulator bit set
// - branch input empty, branch output full
// - timer branch always clears overflow flag
// - decrement register, branch when nonzero
// - 0xF6 branches when carry set
// - user flag one clear or complement
// - host read clears input, write sets output
module alu_branch_core
    import alu_branch_pkg::*;
#(
    parameter int PC_W = 11
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // program memory, read combinationally at prog_addr
    output logic [PC_W-1:0] prog_addr,
    input wire logic [7:0] prog_data,
    // data ram, read combinationally at ram_addr
    output logic [7:0] ram_addr,
    input wire logic [7:0] ram_rdata,
    output logic [7:0] ram_wdata,
    output logic ram_we,
    // host data buffer
    input wire logic [7:0] host_data_buffer,
    input wire logic host_in_buffer_full,
    input wire logic host_out_buffer_full,
    output logic host_in_clear,
    output logic host_out_set,
    output logic [7:0] host_out_data,
    // timer
    input wire logic timer_overflow_flag,
    output logic timer_overflow_clear,
    // visible core state
    output logic [7:0] acc,
    output logic carry,
    output logic auxiliary_carry,
    output logic user_flag_one,
    output logic [PC_W-1:0] pc,
    output logic insn_done
);

    typedef enum logic [1:0] {S_FETCH, S_EXEC, S_INDIR} state_e;

    state_e st_r, st_nxt;
    logic [PC_W-1:0] pc_r, pc_nxt, prog_addr_r, prog_addr_nxt;
    logic [2:0] page_r, page_nxt;
    logic [7:0] opcode_r, opcode_nxt;
    logic [7:0] acc_r, acc_nxt;
    logic carry_r, carry_nxt, aux_r, aux_nxt, flag_one_r, flag_one_nxt;
    logic [7:0] wreg_r [8];
    logic [7:0] wreg_nxt [8];
    logic [7:0] ram_addr_r, ram_addr_nxt, ram_wdata_r, ram_wdata_nxt;
    logic ram_we_r, ram_we_nxt;
    logic in_clear_r, in_clear_nxt, out_set_r, out_set_nxt;
    logic [7:0] out_data_r, out_data_nxt;
    logic tf_clear_r, tf_clear_nxt, done_r, done_nxt;

    // decode helpers
    logic [3:0] hi;
    logic form_reg, form_ind, is_add, is_add_with_carry, is_and, is_or, is_xor;
    logic [7:0] oper, wsel, dec_val;
    logic [8:0] sum9;
    logic [4:0] half5;
    logic cin;
    logic [7:0] bcd_fix;
    logic [8:0] da_low9;
    logic [PC_W-1:0] taken_pc, skip_pc;
    logic branch_go, is_branch;

    always_comb begin
        hi = opcode_r[7:4];
        form_reg = opcode_r[3];
        form_ind = (opcode_r[3:1] == 3'b000);
        wsel = wreg_r[opcode_r[2:0]];
        // immediates ride in the second byte, which sits at prog_addr during S_EXEC
        oper = (opcode_r[3:0] == 4'h3) ? prog_data : (form_reg ? wsel : ram_rdata);
        is_add = (opcode_r == OP_ADD_IMM) || (hi == GRP_ADD && (form_reg || form_ind));
        is_add_with_carry = (opcode_r == OP_ADD_WITH_CARRY_IMM) || (hi == GRP_ADD_WITH_CARRY && (form_reg || form_ind));
        is_and = (opcode_r == OP_ANL_IMM) || (hi == GRP_ANL && (form_reg || form_ind));
        is_or = (opcode_r == OP_ORL_IMM) || (hi == GRP_ORL && (form_reg || form_ind));
        is_xor = (opcode_r == OP_XRL_IMM) || (hi == GRP_XRL && (form_reg || form_ind));
        cin = is_add_with_carry & carry_r;
        sum9 = {1'b0, acc_r} + {1'b0, oper} + {8'h00, cin};
        half5 = {1'b0, acc_r[3:0]} + {1'b0, oper[3:0]} + {4'h0, cin};
        dec_val = wsel - 8'h01;
        bcd_fix = 8'h00;
        if (acc_r[3:0] > BCD_MAX_DIGIT || aux_r) begin
            bcd_fix = bcd_fix | BCD_LOW_FIX;
        end
        // high digit is judged after the low fix, whose carry may ripple into it
        da_low9 = {1'b0, acc_r} + {1'b0, bcd_fix};
        if (da_low9[7:4] > BCD_MAX_DIGIT || da_low9[8] || carry_r) begin
            bcd_fix = bcd_fix | BCD_HIGH_FIX;
        end
        // bits 10:8 come from the branch opcode's own address
        taken_pc = {page_r, prog_data};
        skip_pc = pc_r + PC_W'(1);
        is_branch = 1'b1;
        branch_go = 1'b0;
        if (opcode_r[4:0] == LOW_BIT_TEST) begin
            branch_go = acc_r[opcode_r[7:5]];
        end else if (opcode_r == OP_BRANCH_INPUT_EMPTY) begin
            branch_go = ~host_in_buffer_full;
        end else if (opcode_r == OP_BRANCH_OUTPUT_FULL) begin
            branch_go = host_out_buffer_full;
        end else if (opcode_r == OP_BRANCH_TIMER) begin
            branch_go = timer_overflow_flag;
        end else if (opcode_r == OP_BRANCH_CARRY) begin
            branch_go = carry_r;
        end else if (hi == GRP_DEC_BRANCH && form_reg) begin
            branch_go = (dec_val != 8'h00);
        end else begin
            is_branch = 1'b0;
        end
    end

    always_comb begin
        st_nxt = st_r;
        pc_nxt = pc_r;
        page_nxt = page_r;
        opcode_nxt = opcode_r;
        acc_nxt = acc_r;
        carry_nxt = carry_r;
        aux_nxt = aux_r;
        flag_one_nxt = flag_one_r;
        wreg_nxt = wreg_r;
        ram_addr_nxt = ram_addr_r;
        ram_wdata_nxt = ram_wdata_r;
        ram_we_nxt = 1'b0;
        in_clear_nxt = 1'b0;
        out_set_nxt = 1'b0;
        out_data_nxt = out_data_r;
        tf_clear_nxt = 1'b0;
        done_nxt = 1'b0;
        prog_addr_nxt = prog_addr_r;
        case (st_r)
            S_FETCH: begin
                opcode_nxt = prog_data;
                page_nxt = pc_r[PC_W-1:PC_W-3];
                pc_nxt = pc_r + PC_W'(1);
                prog_addr_nxt = pc_r + PC_W'(1);
                ram_addr_nxt = wreg_r[{2'b00, prog_data[0]}];
                st_nxt = S_EXEC;
            end
            S_EXEC: begin
                st_nxt = S_FETCH;
                done_nxt = 1'b1;
                if (is_add || is_add_with_carry) begin
                    acc_nxt = sum9[7:0];
                    carry_nxt = sum9[8];
                    aux_nxt = half5[4];
                end else if (is_and) begin
                    acc_nxt = acc_r & oper;
                end else if (is_or) begin
                    acc_nxt = acc_r | oper;
                end else if (is_xor) begin
                    acc_nxt = acc_r ^ oper;
                end
                // immediate forms consume the second byte
                if ((is_add || is_add_with_carry || is_and || is_or || is_xor) && opcode_r[3:0] == 4'h3) begin
                    pc_nxt = skip_pc;
                end
                case (opcode_r)
                    OP_INC_A: acc_nxt = acc_r + 8'h01;
                    OP_DEC_A: acc_nxt = acc_r - 8'h01;
                    OP_CLR_A: acc_nxt = 8'h00;
                    OP_CPL_A: acc_nxt = ~acc_r;
                    OP_DECIMAL_ADJUST: begin
                        {carry_nxt, acc_nxt} = {1'b0, acc_r} + {1'b0, bcd_fix};
                        aux_nxt = ({1'b0, acc_r[3:0]} + {1'b0, bcd_fix[3:0]}) > 5'h0F;
                    end
                    OP_SWAP_A: acc_nxt = {acc_r[3:0], acc_r[7:4]};
                    OP_ROT_LEFT: acc_nxt = {acc_r[6:0], acc_r[7]};
                    OP_ROT_LEFT_CARRY: begin
                        acc_nxt = {acc_r[6:0], carry_r};
                        carry_nxt = acc_r[7];
                    end
                    OP_ROT_RIGHT: acc_nxt = {acc_r[0], acc_r[7:1]};
                    OP_ROT_RIGHT_CARRY: begin
                        acc_nxt = {carry_r, acc_r[7:1]};
                        carry_nxt = acc_r[0];
                    end
                    OP_CLR_FLAG_ONE: flag_one_nxt = 1'b0;
                    OP_CPL_FLAG_ONE: flag_one_nxt = ~flag_one_r;
                    OP_HOST_READ: begin
                        acc_nxt = host_data_buffer;
                        in_clear_nxt = 1'b1;
                    end
                    OP_HOST_WRITE: begin
                        out_data_nxt = acc_r;
                        out_set_nxt = 1'b1;
                    end
                    OP_INDIRECT_PAGE_JUMP: begin
                        // page taken after the fetch increment, so offset 255 lands on the next page
                        prog_addr_nxt = {pc_r[PC_W-1:PC_W-3], acc_r};
                        st_nxt = S_INDIR;
                        done_nxt = 1'b0;
                    end
                    default: begin
                    end
                endcase
                if (hi == GRP_INC && form_reg) begin
                    wreg_nxt[opcode_r[2:0]] = wsel + 8'h01;
                end
                if (hi == GRP_INC && form_ind) begin
                    ram_wdata_nxt = ram_rdata + 8'h01;
                    ram_we_nxt = 1'b1;
                end
                if (hi == GRP_DEC && form_reg) begin
                    wreg_nxt[opcode_r[2:0]] = dec_val;
                end
                if (hi == GRP_DEC_BRANCH && form_reg) begin
                    wreg_nxt[opcode_r[2:0]] = dec_val;
                end
                if (opcode_r == OP_BRANCH_TIMER) begin
                    tf_clear_nxt = 1'b1;
                end
                if (opcode_r[4:0] == LOW_JUMP) begin
                    pc_nxt = {opcode_r[7:5], prog_data};
                end else if (is_branch) begin
                    pc_nxt = branch_go ? taken_pc : skip_pc;
                end
                if (st_nxt == S_FETCH) begin
                    prog_addr_nxt = pc_nxt;
                end
            end
            S_INDIR: begin
                pc_nxt = {pc_r[PC_W-1:PC_W-3], prog_data};
                prog_addr_nxt = {pc_r[PC_W-1:PC_W-3], prog_data};
                done_nxt = 1'b1;
                st_nxt = S_FETCH;
            end
            default: st_nxt = S_FETCH;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_r <= S_FETCH;
            pc_r <= PC_RST;
            prog_addr_r <= PC_RST;
            page_r <= 3'h0;
            opcode_r <= OPCODE_RST;
            acc_r <= ACC_RST;
            carry_r <= 1'b0;
            aux_r <= 1'b0;
            flag_one_r <= 1'b0;
            wreg_r <= '{default: WREG_RST};
            ram_addr_r <= 8'h00;
            ram_wdata_r <= 8'h00;
            ram_we_r <= 1'b0;
            in_clear_r <= 1'b0;
            out_set_r <= 1'b0;
            out_data_r <= 8'h00;
            tf_clear_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            pc_r <= pc_nxt;
            prog_addr_r <= prog_addr_nxt;
            page_r <= page_nxt;
            opcode_r <= opcode_nxt;
            acc_r <= acc_nxt;
            carry_r <= carry_nxt;
            aux_r <= aux_nxt;
            flag_one_r <= flag_one_nxt;
            wreg_r <= wreg_nxt;
            ram_addr_r <= ram_addr_nxt;
            ram_wdata_r <= ram_wdata_nxt;
            ram_we_r <= ram_we_nxt;
            in_clear_r <= in_clear_nxt;
            out_set_r <= out_set_nxt;
            out_data_r <= out_data_nxt;
            tf_clear_r <= tf_clear_nxt;
            done_r <= done_nxt;
        end
    end

    assign prog_addr = prog_addr_r;
    assign ram_addr = ram_addr_r;
    assign ram_wdata = ram_wdata_r;
    assign ram_we = ram_we_r;
    assign host_in_clear = in_clear_r;
    assign host_out_set = out_set_r;
    assign host_out_data = out_data_r;
    assign timer_overflow_clear = tf_clear_r;
    assign acc = acc_r;
    assign carry = carry_r;
    assign auxiliary_carry = aux_r;
    assign user_flag_one = flag_one_r;
    assign pc = pc_r;
    assign insn_done = done_r;

endmodule : alu_branch_core

// file: bench/prog_ram_model.sv
`timescale 1ns/100ps
module prog_ram_model #(
    parameter int PC_W = 11
) (
    // clock
    input wire logic ref_clk,
    // program memory, combinational read
    input wire logic [PC_W-1:0] prog_addr,
    output logic [7:0] prog_data,
    // data ram, combinational read, write on the pulse edge
    input wire logic [7:0] ram_addr,
    output logic [7:0] ram_rdata,
    input wire logic [7:0] ram_wdata,
    input wire logic ram_we
);
    logic [7:0] rom [2**PC_W];
    logic [7:0] ram [256];
    initial begin
        foreach (rom[i]) rom[i] = 8'h00;
        foreach (ram[i]) ram[i] = 8'h00;
    end
    assign prog_data = rom[prog_addr];
    assign ram_rdata = ram[ram_addr];
    always @(posedge ref_clk) begin
        if (ram_we) ram[ram_addr] <= ram_wdata;
    end
endmodule : prog_ram_model

// file: bench/alu_branch_checker.sv
`timescale 1ns/100ps
module alu_branch_checker
    import alu_branch_pkg::*;
#(
    parameter int PC_W = 11
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // memories
    input wire logic [7:0] prog_data,
    input wire logic [7:0] ram_rdata,
    input wire logic [7:0] ram_wdata,
    input wire logic ram_we,
    // host and timer
    input wire logic [7:0] host_data_buffer,
    input wire logic host_in_clear,
    input wire logic host_out_set,
    input wire logic [7:0] host_out_data,
    input wire logic timer_overflow_clear,
    // core state
    input wire logic [7:0] acc,
    input wire logic carry,
    input wire logic [PC_W-1:0] pc,
    input wire logic insn_done
);
    // insn_done marks the fetch cycle of the next opcode, so snapshot there
    logic [7:0] op_r, acc_r;
    logic [PC_W-1:0] pc_r;
    logic c_r, v_r, fin;
    always_ff @(posedge ref_clk) begin
        v_r <= srst ? 1'b0 : (v_r | insn_done);
        if (insn_done) begin
            op_r <= prog_data;
            acc_r <= acc;
            c_r <= carry;
            pc_r <= pc;
        end
    end
    assign fin = insn_done && v_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    property p_tclr;
        fin |-> timer_overflow_clear == (op_r == OP_BRANCH_TIMER);
    endproperty
    a_tclr: assert property (p_tclr) else $error("timer clear mismatch");
    property p_hrd;
        host_in_clear |-> insn_done && acc == $past(host_data_buffer);
    endproperty
    a_hrd: assert property (p_hrd) else $error("host read mismatch");
    property p_hwr;
        host_out_set |-> insn_done && host_out_data == acc;
    endproperty
    a_hwr: assert property (p_hwr) else $error("host write mismatch");
    property p_ram;
        ram_we |-> ram_wdata == 8'($past(ram_rdata) + 8'h01);
    endproperty
    a_ram: assert property (p_ram) else $error("indirect increment mismatch");
    property p_swap;
        fin && op_r == OP_SWAP_A |-> acc == {acc_r[3:0], acc_r[7:4]} && carry == c_r;
    endproperty
    a_swap: assert property (p_swap) else $error("swap mismatch");
    property p_rlc;
        fin && op_r == OP_ROT_LEFT_CARRY |-> acc == {acc_r[6:0], c_r} && carry == acc_r[7];
    endproperty
    a_rlc: assert property (p_rlc) else $error("rotate left mismatch");
    property p_rrc;
        fin && op_r == OP_ROT_RIGHT_CARRY |-> acc == {c_r, acc_r[7:1]} && carry == acc_r[0];
    endproperty
    a_rrc: assert property (p_rrc) else $error("rotate right mismatch");
    property p_jc;
        fin && op_r == OP_BRANCH_CARRY && !c_r |-> pc == pc_r + PC_W'(2);
    endproperty
    a_jc: assert property (p_jc) else $error("carry branch mismatch");
    c_tclr: cover property (timer_overflow_clear);
    c_ram: cover property (ram_we);
    c_hwr: cover property (host_out_set);
endmodule : alu_branch_checker

bind alu_branch_core alu_branch_checker #(.PC_W(PC_W)) u_chk (
    .ref_clk, .srst, .prog_data, .ram_rdata, .ram_wdata, .ram_we, .host_data_buffer,
    .host_in_clear, .host_out_set, .host_out_data, .timer_overflow_clear, .acc, .carry,
    .pc, .insn_done
);

// file: bench/test_slave_mcu_alu_branch_decode.sv
`timescale 1ns/100ps
module test_slave_mcu_alu_branch_decode;
    import alu_branch_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] host_data_buffer = 8'h5A;
    logic host_in_buffer_full = 1'b0;
    logic host_out_buffer_full = 1'b0;
    logic timer_overflow_flag = 1'b1;
    logic [10:0] prog_addr, pc;
    logic [7:0] prog_data, ram_addr, ram_rdata, ram_wdata, host_out_data, acc;
    logic ram_we, host_in_clear, host_out_set, timer_overflow_clear;
    logic carry, auxiliary_carry, user_flag_one, insn_done;
    int fails = 0;
    int checks_done = 0;
    int n_tclr = 0;
    int n_clr = 0;
    int n_set = 0;

    always #5 ref_clk = ~ref_clk;

    alu_branch_core dut (
        .ref_clk, .srst, .prog_addr, .prog_data, .ram_addr, .ram_rdata, .ram_wdata, .ram_we,
        .host_data_buffer, .host_in_buffer_full, .host_out_buffer_full, .host_in_clear,
        .host_out_set, .host_out_data, .timer_overflow_flag, .timer_overflow_clear, .acc,
        .carry, .auxiliary_carry, .user_flag_one, .pc, .insn_done
    );
    prog_ram_model mem (
        .ref_clk, .prog_addr, .prog_data, .ram_addr, .ram_rdata, .ram_wdata, .ram_we
    );

    // stand-ins for the timer and host side: they answer the core's timer clear and output set pulses
    always @(posedge ref_clk) begin
        if (timer_overflow_clear) timer_overflow_flag <= 1'b0;
        if (host_out_set) host_out_buffer_full <= 1'b1;
        n_tclr <= n_tclr + int'(timer_overflow_clear);
        n_clr <= n_clr + int'(host_in_clear);
        n_set <= n_set + int'(host_out_set);
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    task automatic cmp(input string w, input logic [10:0] e, input logic [10:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask : cmp

    task automatic ld(input logic [10:0] a, input int n, input logic [255:0] v);
        for (int i = 0; i < n; i++) mem.rom[a + 11'(i)] = v[8*(n-1-i) +: 8];
    endtask : ld

    // f is {flag one, carry, aux}; a hung core never raises insn_done
    task automatic ex(input logic [10:0] p, input logic [7:0] a, input logic [2:0] f);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (insn_done !== 1'b1 && n < 8);
        if (insn_done !== 1'b1) begin
            fails++;
            tally_and_finish();
        end else begin
            cmp("pc", p, pc);
            cmp("acc", {3'h0, a}, {3'h0, acc});
            cmp("flags", {8'h00, f}, {8'h00, user_flag_one, carry, auxiliary_carry});
        end
    endtask : ex

    initial begin
        #1;
        ld(11'h000, 29, 232'h033C03C8130F53F0432A57D3E03747E7F7677717072707F6330301F640);
        ld(11'h040, 4, 32'h1A1AEA50);
        ld(11'h050, 10, 80'hEA531A6ACA6A32601260);
        ld(11'h060, 2, 16'h1670);
        ld(11'h070, 4, 32'h167FD680);
        ld(11'h080, 11, 88'h86902202A5B5B5116084FF);
        ld(11'h4FF, 1, 8'hB3);
        ld(11'h5DA, 1, 8'h30);
        ld(11'h530, 5, 40'hD34057A433);
        mem.ram[0] = 8'h7F;
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        ex(11'h002, 8'h3C, 3'h0);
        ex(11'h004, 8'h04, 3'h3);
        ex(11'h006, 8'h14, 3'h1);
        ex(11'h008, 8'h10, 3'h1);
        ex(11'h00A, 8'h3A, 3'h1);
        ex(11'h00B, 8'h40, 3'h1);
        ex(11'h00D, 8'hA0, 3'h1);
        ex(11'h00E, 8'h5F, 3'h1);
        ex(11'h00F, 8'hF5, 3'h1);
        ex(11'h010, 8'hEB, 3'h1);
        ex(11'h011, 8'hD6, 3'h3);
        ex(11'h012, 8'hEB, 3'h1);
        ex(11'h013, 8'hF5, 3'h1);
        ex(11'h014, 8'hF6, 3'h1);
        ex(11'h015, 8'hF5, 3'h1);
        ex(11'h016, 8'h00, 3'h1);
        ex(11'h017, 8'hFF, 3'h1);
        ex(11'h019, 8'hFF, 3'h1);
        ex(11'h01B, 8'h00, 3'h3);
        ex(11'h040, 8'h00, 3'h3);
        ex(11'h041, 8'h00, 3'h3);
        ex(11'h042, 8'h00, 3'h3);
        ex(11'h050, 8'h00, 3'h3);
        ex(11'h052, 8'h00, 3'h3);
        ex(11'h053, 8'h00, 3'h3);
        ex(11'h054, 8'h01, 3'h0);
        ex(11'h055, 8'h01, 3'h0);
        ex(11'h056, 8'h01, 3'h0);
        ex(11'h058, 8'h01, 3'h0);
        ex(11'h060, 8'h01, 3'h0);
        ex(11'h070, 8'h01, 3'h0);
        ex(11'h072, 8'h01, 3'h0);
        ex(11'h080, 8'h01, 3'h0);
        ex(11'h082, 8'h01, 3'h0);
        ex(11'h083, 8'h5A, 3'h0);
        ex(11'h084, 8'h5A, 3'h0);
        ex(11'h085, 8'h5A, 3'h0);
        ex(11'h086, 8'h5A, 3'h4);
        ex(11'h087, 8'h5A, 3'h0);
        ex(11'h088, 8'h5A, 3'h0);
        ex(11'h089, 8'hDA, 3'h0);
        ex(11'h4FF, 8'hDA, 3'h0);
        ex(11'h530, 8'hDA, 3'h0);
        ex(11'h532, 8'h9A, 3'h0);
        ex(11'h533, 8'h00, 3'h3);
        cmp("timer clears", 11'h002, 11'(n_tclr));
        cmp("input clears", 11'h001, 11'(n_clr));
        cmp("output sets", 11'h001, 11'(n_set));
        cmp("output data", {3'h0, 8'h5A}, {3'h0, host_out_data});
        cmp("ram byte", {3'h0, 8'h80}, {3'h0, mem.ram[0]});
        tally_and_finish();
    end
endmodule : test_slave_mcu_alu_branch_decode
